// >>> bsgp_pins.sv
// boot strap capture, general purpose pins, card supply and infrared/uart pin sharing
//
// What this block does
// - strap pull-up stays on while chip reset input is low
// - strap pull-up turns off a few clocks after chip reset rises
// - strap pin level is captured on the chip reset rising edge
// - captured strap level reads as a bit of gp_input_reg_one
// - captured low selects program fetch from external memory bus
// - captured high selects program execution from internal ROM
// - after reset strap pin works as general pin or serial receive input
// - strap pin can drive bank_address_top for upper half of external memory
// - general pins except last are input, edge interrupt or output
// - three pins switch between general use and card supply output
// - last general pin is input or output only, no interrupt
// - infrared_speed_indicator shows selected infrared link speed
// - receive input routes to infrared receiver or uart receive line
// - transmit output comes from infrared transmitter or uart transmit
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ns
module bsgp_pins
  import bsgp_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic                 chipResetInN,
  input  wire logic [ADDR_W-1:0]    addr,
  input  wire logic [DATA_W-1:0]    wdata,
  input  wire logic                 wstb,
  input  wire logic                 rstb,
  output logic      [DATA_W-1:0]    rdata,
  input  wire logic [PIN_COUNT-1:0] pinIn,
  output logic      [PIN_COUNT-1:0] pinOut,
  output logic      [PIN_COUNT-1:0] pinOe,
  output logic                      strapPullupEn,
  output logic                      bootMemorySelect,
  output logic                      fetchExternal,
  input  wire logic                 codeBankTop,
  input  wire logic [2:0]           cardPowerReq,
  output logic                      cardSupplyOutA,
  output logic                      cardSupplyOutB,
  output logic                      cardSupplyOutC,
  input  wire logic                 infraredReceiveIn,
  output logic                      infraredTransmitOut,
  output logic                      infraredSpeedIndicator,
  output logic                      irRxData,
  output logic                      uartRxData,
  input  wire logic                 irTxData,
  input  wire logic                 uartTxData,
  output logic      [IRQ_PINS-1:0]  pendingFlags
);

  logic [DATA_W-1:0]    outData_reg;
  logic [DATA_W-1:0]    direction_reg;
  logic [DATA_W-1:0]    irqEnable_reg;
  logic [DATA_W-1:0]    edgeSelect_reg;
  logic [DATA_W-1:0]    function_reg;
  logic [IRQ_PINS-1:0]  pending_reg;
  logic [IRQ_PINS-1:0]  pending_next;
  logic [PIN_COUNT-1:0] pinPrev_reg;
  logic                 resetInPrev_reg;
  logic                 bootSel_reg;
  bsgp_pull_t           pull_reg;
  bsgp_pull_t           pull_next;
  logic [2:0]           pullCount_reg;
  logic [DATA_W-1:0]    rdata_reg;
  logic                 txOut_reg;
  logic                 irRx_reg;
  logic                 uartRx_reg;
  logic                 speed_reg;

  wire                  chipHeld   = ~chipResetInN;
  wire                  riseSeen   = chipResetInN & ~resetInPrev_reg;
  wire                  ctrlClear  = srst | chipHeld;
  wire                  wrOut      = wstb & (addr == OUT_DATA_OFS);
  wire                  wrDir      = wstb & (addr == DIRECTION_OFS);
  wire                  wrIrqEn    = wstb & (addr == IRQ_ENABLE_OFS);
  wire                  wrEdge     = wstb & (addr == EDGE_SELECT_OFS);
  wire                  wrPend     = wstb & (addr == PENDING_OFS);
  wire                  wrFunc     = wstb & (addr == FUNCTION_OFS);
  wire [IRQ_PINS-1:0]   clrMask    = wrPend ? wdata[IRQ_PINS-1:0] : '0;
  wire                  strapRx    = function_reg[FN_STRAP_RX];
  wire                  bankEn     = function_reg[FN_BANK_EN];
  wire                  irMode     = function_reg[FN_INFRARED_SPEED_INDICATOR];
  wire [2:0]            cardSel    = {function_reg[FN_CARD_C], function_reg[FN_CARD_B],
                                      function_reg[FN_CARD_A]};
  wire [PIN_COUNT-1:0]  cardMask   = {1'b0, cardSel[2], cardSel[1], 1'b0, cardSel[0],
                                      2'b00};
  wire [DATA_W-1:0]     gpInValue  = {bootSel_reg, pinIn};
  wire [DATA_W-1:0]     pendValue  = {2'b00, pending_reg};

  // strap pull-up sequencing
  always_comb begin
    pull_next = pull_reg;
    case (pull_reg)
      PU_ON:   if (riseSeen) pull_next = PU_HOLD;
      PU_HOLD: begin
        if (chipHeld) pull_next = PU_ON;
        else if (pullCount_reg == PULLUP_LAST) pull_next = PU_OFF;
      end
      PU_OFF:  if (chipHeld) pull_next = PU_ON;
      default: pull_next = PU_ON;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pull_reg        <= PU_ON;
      pullCount_reg   <= 3'h0;
      resetInPrev_reg <= 1'b0;
    end else begin
      pull_reg        <= pull_next;
      pullCount_reg   <= (pull_reg == PU_HOLD) ? pullCount_reg + 3'h1 : 3'h0;
      resetInPrev_reg <= chipResetInN;
    end
  end

  assign strapPullupEn = chipHeld | (pull_reg != PU_OFF);

  // strap capture at the release of chip reset
  always_ff @(posedge clock) begin
    if (srst) begin
      bootSel_reg <= BOOT_SEL_RST;
    end else if (riseSeen) begin
      bootSel_reg <= pinIn[STRAP_IDX];
    end
  end

  assign bootMemorySelect = bootSel_reg;
  assign fetchExternal    = ~bootSel_reg;

  // control registers, cleared while the chip is held in reset
  always_ff @(posedge clock) begin
    if (ctrlClear) begin
      outData_reg    <= OUT_DATA_RST;
      direction_reg  <= DIRECTION_RST;
      irqEnable_reg  <= IRQ_ENABLE_RST;
      edgeSelect_reg <= EDGE_SELECT_RST;
      function_reg   <= FUNCTION_RST;
    end else begin
      if (wrOut) outData_reg <= wdata;
      if (wrDir) direction_reg <= wdata;
      if (wrIrqEn) irqEnable_reg <= wdata;
      if (wrEdge) edgeSelect_reg <= wdata;
      if (wrFunc) function_reg <= wdata;
    end
  end

  // per pin drive and edge detection
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      if (gi == STRAP_IDX) begin : g_strap
        // bank bit overrides; receive use keeps the pin an input
        assign pinOut[gi] = bankEn ? codeBankTop : outData_reg[gi];
        assign pinOe[gi]  = ~chipHeld & ~strapRx &
                            (bankEn | direction_reg[gi]);
      end else begin : g_plain
        assign pinOut[gi] = outData_reg[gi];
        assign pinOe[gi]  = ~chipHeld & ~cardMask[gi] & direction_reg[gi];
      end
      if (gi != LAST_IDX) begin : g_irq
        wire edgeHit = edgeSelect_reg[gi] ? (pinIn[gi] & ~pinPrev_reg[gi])
                                          : (~pinIn[gi] & pinPrev_reg[gi]);
        wire setHit  = irqEnable_reg[gi] & ~direction_reg[gi] & edgeHit;
        // set wins over a clear in the same cycle
        assign pending_next[gi] = setHit | (pending_reg[gi] & ~clrMask[gi]);
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (ctrlClear) begin
      pending_reg <= '0;
      pinPrev_reg <= '0;
    end else begin
      pending_reg <= pending_next;
      pinPrev_reg <= pinIn;
    end
  end

  assign pendingFlags = pending_reg;

  // card supply outputs
  assign cardSupplyOutA = cardSel[0] & cardPowerReq[0];
  assign cardSupplyOutB = cardSel[1] & cardPowerReq[1];
  assign cardSupplyOutC = cardSel[2] & cardPowerReq[2];

  // infrared and uart pin sharing
  always_ff @(posedge clock) begin
    if (ctrlClear) begin
      txOut_reg  <= 1'b1;
      irRx_reg   <= 1'b1;
      uartRx_reg <= 1'b1;
      speed_reg  <= 1'b0;
    end else begin
      txOut_reg  <= irMode ? irTxData : uartTxData;
      irRx_reg   <= irMode ? infraredReceiveIn : 1'b1;
      uartRx_reg <= strapRx ? pinIn[STRAP_IDX] : (irMode ? 1'b1 : infraredReceiveIn);
      speed_reg  <= irMode & function_reg[FN_IR_FAST];
    end
  end

  assign infraredTransmitOut    = txOut_reg;
  assign irRxData               = irRx_reg;
  assign uartRxData             = uartRx_reg;
  assign infraredSpeedIndicator = speed_reg;

  // register read port, data in the following cycle only
  wire [DATA_W-1:0] readMux =
    (addr == GP_INPUT_ONE_OFS) ? gpInValue :
    (addr == OUT_DATA_OFS)     ? outData_reg :
    (addr == DIRECTION_OFS)    ? direction_reg :
    (addr == IRQ_ENABLE_OFS)   ? irqEnable_reg :
    (addr == EDGE_SELECT_OFS)  ? edgeSelect_reg :
    (addr == PENDING_OFS)      ? pendValue :
    (addr == FUNCTION_OFS)     ? function_reg : 8'h00;

  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rstb ? readMux : 8'h00;
    end
  end

  assign rdata = rdata_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_pullupHeld;
    chipHeld |-> strapPullupEn;
  endproperty
  a_pullupHeld: assert property (p_pullupHeld) else $error("pull-up off during reset");

  property p_pullupLate;
    riseSeen |=> strapPullupEn [*4];
  endproperty
  a_pullupLate: assert property (p_pullupLate) else $error("pull-up dropped early");

  property p_pullupOff;
    riseSeen ##1 chipResetInN [*5] |-> !strapPullupEn;
  endproperty
  a_pullupOff: assert property (p_pullupOff) else $error("pull-up still on");

  property p_strapCapture;
    riseSeen |=> bootMemorySelect == $past(pinIn[STRAP_IDX]);
  endproperty
  a_strapCapture: assert property (p_strapCapture) else $error("strap not captured");

  property p_strapRead;
    rstb && addr == GP_INPUT_ONE_OFS && !riseSeen |=> rdata[BOOT_SEL_BIT] == bootMemorySelect;
  endproperty
  a_strapRead: assert property (p_strapRead) else $error("strap bit misread");

  property p_externalFetch;
    riseSeen && !pinIn[STRAP_IDX] |=> fetchExternal && !bootMemorySelect;
  endproperty
  a_externalFetch: assert property (p_externalFetch) else $error("external fetch missed");

  property p_lastNoIrq;
    rstb && addr == PENDING_OFS |=> rdata[LAST_IDX] == 1'b0;
  endproperty
  a_lastNoIrq: assert property (p_lastNoIrq) else $error("last pin shows pending");

  property p_pendSticky;
    !chipHeld ##1 !chipHeld |->
      (pending_reg & $past(pending_reg & ~clrMask)) == $past(pending_reg & ~clrMask);
  endproperty
  a_pendSticky: assert property (p_pendSticky) else $error("pending flag lost");

  property p_cardNoDrive;
    cardSel[0] |-> !pinOe[CARD_A_IDX];
  endproperty
  a_cardNoDrive: assert property (p_cardNoDrive) else $error("card pin driven as gpio");

  property p_txRoute;
    !ctrlClear && irMode |=> infraredTransmitOut == $past(irTxData);
  endproperty
  a_txRoute: assert property (p_txRoute) else $error("transmit not from infrared");

  property p_rxNoDrive;
    strapRx |-> !pinOe[STRAP_IDX];
  endproperty
  a_rxNoDrive: assert property (p_rxNoDrive) else $error("rx pin driven");

  property p_bankDrive;
    bankEn && !strapRx && !chipHeld |-> pinOe[STRAP_IDX] && pinOut[STRAP_IDX] == codeBankTop;
  endproperty
  a_bankDrive: assert property (p_bankDrive) else $error("bank bit not on strap pin");

  property p_fallSets;
    !ctrlClear && irqEnable_reg[1] && !direction_reg[1] && !edgeSelect_reg[1] &&
      $fell(pinIn[1]) |=> pendingFlags[1];
  endproperty
  a_fallSets: assert property (p_fallSets) else $error("falling edge not pending");

  property p_rxRoute;
    !ctrlClear && irMode |=> irRxData == $past(infraredReceiveIn);
  endproperty
  a_rxRoute: assert property (p_rxRoute) else $error("receive not from infrared");

  c_strapLow: cover property (riseSeen && !pinIn[STRAP_IDX]);
  c_pendingSet: cover property (pending_reg[1] && wrPend && wdata[1]);
  c_irMode: cover property (irMode && infraredSpeedIndicator);
  c_bankDrive: cover property (bankEn && pinOe[STRAP_IDX]);
endmodule

// >>> bsgp_pkg.sv
// constants for the boot strap and general purpose pin block
package bsgp_pkg;
  localparam int unsigned ADDR_W      = 3;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned PIN_COUNT   = 7;
  localparam int unsigned IRQ_PINS    = 6;
  localparam int unsigned STRAP_IDX   = 0;
  localparam int unsigned LAST_IDX    = 6;
  localparam int unsigned CARD_A_IDX  = 2;
  localparam int unsigned CARD_B_IDX  = 4;
  localparam int unsigned CARD_C_IDX  = 5;

  localparam logic [ADDR_W-1:0] GP_INPUT_ONE_OFS = 3'h0;
  localparam logic [ADDR_W-1:0] OUT_DATA_OFS     = 3'h1;
  localparam logic [ADDR_W-1:0] DIRECTION_OFS    = 3'h2;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS   = 3'h3;
  localparam logic [ADDR_W-1:0] EDGE_SELECT_OFS  = 3'h4;
  localparam logic [ADDR_W-1:0] PENDING_OFS      = 3'h5;
  localparam logic [ADDR_W-1:0] FUNCTION_OFS     = 3'h6;

  localparam int unsigned BOOT_SEL_BIT  = 7;
  localparam int unsigned FN_STRAP_RX   = 0;
  localparam int unsigned FN_BANK_EN    = 1;
  localparam int unsigned FN_CARD_A     = 2;
  localparam int unsigned FN_CARD_B     = 3;
  localparam int unsigned FN_CARD_C     = 4;
  localparam int unsigned FN_INFRARED_SPEED_INDICATOR    = 5;
  localparam int unsigned FN_IR_FAST    = 6;

  localparam logic [DATA_W-1:0] OUT_DATA_RST    = 8'h00;
  localparam logic [DATA_W-1:0] DIRECTION_RST   = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_ENABLE_RST  = 8'h00;
  localparam logic [DATA_W-1:0] EDGE_SELECT_RST = 8'h00;
  localparam logic [DATA_W-1:0] FUNCTION_RST    = 8'h00;
  localparam logic              BOOT_SEL_RST    = 1'b1;

  localparam int unsigned CLOCK_PERIOD_NS    = 10;
  localparam int unsigned RESET_MIN_NS       = 1000;
  localparam int unsigned RESET_MIN_CYCLES   =
    (RESET_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned PULLUP_HOLD_CYCLES = 4;
  localparam logic [2:0]  PULLUP_LAST        = 3'(PULLUP_HOLD_CYCLES - 1);

  typedef enum logic [1:0] {PU_ON, PU_HOLD, PU_OFF} bsgp_pull_t;
endpackage

// >>> bsgp_board.sv
// board model: strap resistor and external drivers on the pins
`timescale 1ns/1ns
module bsgp_board
  import bsgp_pkg::*;
(
  input  wire logic [PIN_COUNT-1:0] pinOut,
  input  wire logic [PIN_COUNT-1:0] pinOe,
  input  wire logic                 strapPullupEn,
  input  wire logic                 strapPullDown,
  input  wire logic [PIN_COUNT-1:0] extDrive,
  output logic      [PIN_COUNT-1:0] pinIn,
  output logic      [1:0]           factoryTestInN
);
  // unused factory test inputs tied high on the board
  assign factoryTestInN = 2'b11;
  logic strapIdle;
  // external pull-down wins over the weak internal pull-up
  assign strapIdle = strapPullDown ? 1'b0 : (strapPullupEn ? 1'b1 : extDrive[0]);
  assign pinIn = (pinOe & pinOut) | (~pinOe & {extDrive[PIN_COUNT-1:1], strapIdle});
endmodule

// >>> bsgp_tb.sv
// testbench for the boot strap and general purpose pin block
`timescale 1ns/1ns
module tb
  import bsgp_pkg::*;
;
  logic                 clock, srst, chipResetInN, wstb, rstb, strapPullupEn;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdata, rdata, d;
  logic [PIN_COUNT-1:0] pinIn, pinOut, pinOe, extDrive;
  logic                 bootMemorySelect, fetchExternal, codeBankTop, strapPullDown;
  logic [2:0]           cardPowerReq;
  logic [1:0]           factoryTestInN;
  logic                 cardSupplyOutA, cardSupplyOutB, cardSupplyOutC;
  logic                 infraredReceiveIn, infraredTransmitOut, infraredSpeedIndicator;
  logic                 irRxData, uartRxData, irTxData, uartTxData;
  logic [IRQ_PINS-1:0]  pendingFlags;
  int                   fails, cmp_count;
  int                   cardIdx [3] = '{CARD_A_IDX, CARD_B_IDX, CARD_C_IDX};

  bsgp_pins i_dut (.clock, .srst, .chipResetInN, .addr, .wdata, .wstb, .rstb, .rdata,
    .pinIn, .pinOut, .pinOe, .strapPullupEn, .bootMemorySelect, .fetchExternal,
    .codeBankTop, .cardPowerReq, .cardSupplyOutA, .cardSupplyOutB, .cardSupplyOutC,
    .infraredReceiveIn, .infraredTransmitOut, .infraredSpeedIndicator, .irRxData,
    .uartRxData, .irTxData, .uartTxData, .pendingFlags);
  bsgp_board i_board (.pinOut, .pinOe, .strapPullupEn, .strapPullDown, .extDrive, .pinIn,
    .factoryTestInN);

  always #5 clock = ~clock;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clock);
    wstb  <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clock);
    wstb <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clock);
    rstb <= 1'b1;
    addr <= a;
    @(posedge clock);
    rstb <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // system holds chip reset low for the minimum width
  task automatic chipReset(input logic pd);
    @(posedge clock);
    strapPullDown <= pd;
    chipResetInN  <= 1'b0;
    tick(RESET_MIN_CYCLES);
    chk(8'(strapPullupEn), 8'h01);
    chk(8'(pinOe), 8'h00);
    @(posedge clock);
    chipResetInN <= 1'b1;
    tick(2);
    chk(8'(strapPullupEn), 8'h01);
    tick(6);
    chk(8'(strapPullupEn), 8'h00);
    chk({6'h00, bootMemorySelect, fetchExternal}, {6'h00, ~pd, pd});
    rd(GP_INPUT_ONE_OFS, d);
    chk(d & 8'h80, {~pd, 7'h00});
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    results;
  end

  initial begin
    clock = 0; srst = 1; chipResetInN = 0; addr = 0; wdata = 0; wstb = 0; rstb = 0;
    codeBankTop = 0; cardPowerReq = 0; infraredReceiveIn = 1; irTxData = 1;
    uartTxData = 1; strapPullDown = 1; extDrive = 0; fails = 0; cmp_count = 0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    chipReset(1'b1);
    chipReset(1'b0);
    chk(8'(factoryTestInN), 8'h03);
    wr(DIRECTION_OFS, 8'h7F);
    wr(OUT_DATA_OFS, 8'h55);
    chk({1'b0, pinOe & pinOut}, 8'h55);
    rd(GP_INPUT_ONE_OFS, d);
    chk(d, 8'hD5);
    rd(3'h7, d);
    chk(d, 8'h00);
    wr(DIRECTION_OFS, 8'h00);
    @(posedge clock) extDrive <= 7'h2A;
    rd(GP_INPUT_ONE_OFS, d);
    chk(d, 8'hAA);
    wr(FUNCTION_OFS, 8'h01);
    wr(DIRECTION_OFS, 8'h01);
    @(posedge clock) extDrive <= 7'h01;
    tick(2);
    chk({pinOe[0], uartRxData}, 8'h01);
    @(posedge clock) extDrive <= 7'h00;
    tick(2);
    chk(8'(uartRxData), 8'h00);
    wr(FUNCTION_OFS, 8'h02);
    @(posedge clock) codeBankTop <= 1'b1;
    tick(1);
    chk({pinOe[0], pinOut[0]}, 8'h03);
    @(posedge clock) codeBankTop <= 1'b0;
    tick(1);
    chk(8'(pinOut[0]), 8'h00);
    wr(DIRECTION_OFS, 8'h7F);
    @(posedge clock) cardPowerReq <= 3'h7;
    for (int k = 0; k < 3; k++) begin
      wr(FUNCTION_OFS, 8'h04 << k);
      chk({cardSupplyOutC, cardSupplyOutB, cardSupplyOutA}, 8'h01 << k);
      chk(8'(pinOe), 8'h7F & ~(8'h01 << cardIdx[k]));
    end
    @(posedge clock) cardPowerReq <= 3'h0;
    tick(1);
    chk({cardSupplyOutC, cardSupplyOutB, cardSupplyOutA}, 8'h00);
    wr(FUNCTION_OFS, 8'h00);
    wr(DIRECTION_OFS, 8'h00);
    wr(EDGE_SELECT_OFS, 8'h01);
    wr(IRQ_ENABLE_OFS, 8'h3F);
    @(posedge clock) extDrive <= 7'h7F;
    tick(3);
    chk(8'(pendingFlags), 8'h01);
    @(posedge clock) extDrive <= 7'h00;
    tick(3);
    chk(8'(pendingFlags), 8'h3F);
    rd(PENDING_OFS, d);
    chk(d, 8'h3F);
    wr(PENDING_OFS, 8'h01);
    chk(8'(pendingFlags), 8'h3E);
    wr(PENDING_OFS, 8'h3E);
    chk(8'(pendingFlags), 8'h00);
    wr(FUNCTION_OFS, 8'h60);
    @(posedge clock);
    irTxData          <= 1'b0;
    infraredReceiveIn <= 1'b0;
    tick(2);
    chk({infraredSpeedIndicator, irRxData, uartRxData, infraredTransmitOut}, 8'h0A);
    wr(FUNCTION_OFS, 8'h20);
    tick(1);
    chk(8'(infraredSpeedIndicator), 8'h00);
    wr(FUNCTION_OFS, 8'h00);
    tick(2);
    chk({infraredSpeedIndicator, irRxData, uartRxData, infraredTransmitOut}, 8'h05);
    results;
  end
endmodule
